/* File: ppp_dev_model.sv */
// behavioural model of the device side of the prom programming pins
`timescale 1ns/100ps
module ppp_dev_model #(
    parameter int MIN_PULSE_NS = 100000
) (
    // programming pins
    input  wire logic        dev_reset_n,
    input  wire logic        vpp_on,
    input  wire logic        vpp_write_sel,
    input  wire logic        enable_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        program_strobe_n,
    input  wire logic [16:0] prog_addr_bus,
    // data bus as split by the host
    input  wire logic [7:0]  host_d,
    input  wire logic        host_oe_n,
    output logic [7:0]       bus_d
);
    logic [7:0]  mem [int];
    logic [7:0]  lat [4];
    logic [7:0]  last = 8'h00;
    logic [7:0]  c_d;
    logic [16:0] c_a;
    logic        c_ok = 1'b0;
    logic        c_page;
    logic        pmode;
    logic        drv;
    int          fail_left = 0;
    int          clash = 0;
    int          bad_mode = 0;
    realtime     t_fall;

    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction

    assign pmode = !dev_reset_n && vpp_on;
    // drive only in read or verify; float on read high, standby, inhibit, page write
    assign drv = pmode && !enable_strobe_n && !read_strobe_n && program_strobe_n;
    // no pull on the lines: a released bus shows the inverse of its last level
    assign bus_d = !host_oe_n ? host_d : drv ? rd(int'(prog_addr_bus)) : ~last;

    always @(host_d, host_oe_n, drv, prog_addr_bus) begin
        if (!host_oe_n) last = host_d;
        else if (drv) last = rd(int'(prog_addr_bus));
    end

    // judged 1 ns after the edge so pins that switch together cannot fake a clash
    always @(host_oe_n, drv) begin
        #1;
        if (!host_oe_n && drv) clash++;
    end

    always @(negedge enable_strobe_n, negedge read_strobe_n, negedge program_strobe_n) begin
        #1;
        if (!pmode) bad_mode++;
    end

    // settled values only: a half-updated pin set must not overwrite a latched byte
    always @(enable_strobe_n, read_strobe_n, program_strobe_n, prog_addr_bus, bus_d) begin
        #1;
        if (pmode && vpp_write_sel && enable_strobe_n && !read_strobe_n && program_strobe_n)
            lat[prog_addr_bus[1:0]] = bus_d;
    end

    // pins are sampled 1 ns after the fall so same-edge pin updates have landed
    always @(negedge program_strobe_n) begin
        t_fall = $realtime;
        #1;
        c_ok   = pmode && vpp_write_sel && read_strobe_n;
        c_page = enable_strobe_n;
        c_a    = prog_addr_bus;
        c_d    = bus_d;
    end

    always @(posedge program_strobe_n) begin
        if (c_ok && ($realtime - t_fall) >= MIN_PULSE_NS) begin
            if (fail_left > 0) fail_left--;
            else if (c_page) for (int k = 0; k < 4; k++) mem[int'(c_a[16:2]) * 4 + k] = lat[k];
            else mem[int'(c_a)] = c_d;
        end
        c_ok = 1'b0;
    end
endmodule // ppp_dev_model

/* File: ppp_host.sv */
// file: programmer-side sequencer driving the prom programming pins
// Functional notes
// - programming mode only while device reset low and supply at read or write level
// - writes stay inside 0000H..EFFFH; last address must be explicitly written
// - after four bytes, one program pulse with enable and read high
// - after page write, verify with enable low and read low
// - repeat write and verify, at most ten attempts
// - byte write: program pulse with enable low, read high, data driven
// - read: reset low, read supply, address, read mode, then sample data
`timescale 1ns/100ps
module ppp_host
    import ppp_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int SETUP_CYCLES = SETUP_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // user command port
    input  wire logic                 cmd_valid,
    input  wire ppp_pkg::ppp_cmd_t    cmd_op,
    input  wire logic [16:0]          cmd_addr,
    input  wire logic [31:0]          cmd_wdata,
    output logic                      cmd_ready,
    output logic                      rsp_valid,
    output logic                      rsp_ok,
    output logic                      rsp_blank,
    output logic [7:0]                rsp_rdata,
    output logic [3:0]                rsp_tries,
    // device pins
    output logic                      dev_reset_n,
    output logic                      vpp_write_sel,
    output logic                      vpp_on,
    output logic                      enable_strobe_n,
    output logic                      read_strobe_n,
    output logic                      program_strobe_n,
    output logic [16:0]               prog_addr_bus,
    output logic [7:0]                prog_data_bus_o,
    output logic                      prog_data_bus_oe_n,
    input  wire logic [7:0]           prog_data_bus_i
);
    import ppp_pkg::*;

    // ************************************************
    // state and registers
    // ************************************************
    ppp_state_t         state_q;
    ppp_cmd_t           op_q;
    logic [16:0]        base_q;
    logic [31:0]        wdata_q;
    logic [1:0]         idx_q;
    logic [3:0]         tries_q;
    logic               mismatch_q;
    logic [7:0]         din_s1_q;
    logic [7:0]         din_s2_q;
    logic               tmr_load;
    logic [TIMER_W-1:0] tmr_count;
    logic               tmr_done;
    logic [7:0]         cur_byte;
    logic [16:0]        cur_addr;
    logic               addr_ok;

    assign cur_byte = wdata_q[{idx_q, 3'h0} +: 8];
    assign cur_addr = (op_q == PPP_CMD_PAGE) ? {base_q[16:2], idx_q} : base_q;
    // reject writes outside the program area
    assign addr_ok  = (cmd_op == PPP_CMD_READ) || (cmd_addr <= ADDR_LAST);

    ppp_timer #(.W(TIMER_W)) u_timer (
        .clk     (clk),
        .nrst    (nrst),
        .load    (tmr_load),
        .count   (tmr_count),
        .expired (tmr_done)
    );

    // data pins come from the device's domain: two flops before use
    always_ff @(posedge clk) begin
        if (!nrst) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end else begin
            din_s1_q <= prog_data_bus_i;
            din_s2_q <= din_s1_q;
        end
    end

    // ************************************************
    // sequencer
    // ************************************************
    always_comb begin
        tmr_load  = 1'b0;
        tmr_count = TIMER_W'(SETUP_CYCLES);
        case (state_q)
            PPP_S_IDLE:  tmr_load = cmd_valid && addr_ok;
            PPP_S_LATCH: tmr_load = tmr_done;
            PPP_S_GAP: begin
                tmr_load  = tmr_done;
                tmr_count = TIMER_W'(PULSE_CYCLES);
            end
            PPP_S_PULSE: tmr_load = tmr_done;
            PPP_S_SETV:  tmr_load = tmr_done;
            PPP_S_VERI:  tmr_load = tmr_done;  // a retry gets its full setup window too
            default:     tmr_load = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q    <= PPP_S_IDLE;
            op_q       <= PPP_CMD_READ;
            base_q     <= 17'h00000;
            wdata_q    <= 32'h00000000;
            idx_q      <= 2'h0;
            tries_q    <= 4'h0;
            mismatch_q <= 1'b0;
        end else begin
            case (state_q)
                PPP_S_IDLE: begin
                    if (cmd_valid && addr_ok) begin
                        op_q       <= cmd_op;
                        base_q     <= cmd_addr;
                        wdata_q    <= cmd_wdata;
                        idx_q      <= 2'h0;
                        tries_q    <= 4'h0;
                        mismatch_q <= 1'b0;
                        case (cmd_op)
                            PPP_CMD_PAGE: state_q <= PPP_S_LATCH;
                            PPP_CMD_BYTE: state_q <= PPP_S_GAP;
                            default:      state_q <= PPP_S_READ;
                        endcase
                    end
                end
                PPP_S_LATCH: if (tmr_done) begin
                    // four latch cycles fill the page
                    idx_q <= idx_q + 2'h1;
                    if (idx_q == PAGE_IDX_LAST) begin
                        state_q <= PPP_S_GAP;
                    end
                end
                PPP_S_GAP: if (tmr_done) begin
                    tries_q <= tries_q + 4'h1;
                    state_q <= PPP_S_PULSE;
                end
                PPP_S_PULSE: if (tmr_done) begin
                    idx_q      <= 2'h0;
                    mismatch_q <= 1'b0;
                    state_q    <= PPP_S_SETV;
                end
                PPP_S_SETV: if (tmr_done) begin
                    state_q <= PPP_S_VERI;
                end
                PPP_S_VERI: if (tmr_done) begin
                    // compare returned byte with intended one
                    if (din_s2_q != cur_byte) begin
                        mismatch_q <= 1'b1;
                    end
                    if (op_q == PPP_CMD_PAGE && idx_q != PAGE_IDX_LAST) begin
                        idx_q <= idx_q + 2'h1;
                    end else if ((mismatch_q || din_s2_q != cur_byte)
                                 && tries_q < MAX_TRIES) begin
                        // retry the write, capped at ten pulses
                        idx_q   <= 2'h0;
                        state_q <= (op_q == PPP_CMD_PAGE) ? PPP_S_LATCH : PPP_S_GAP;
                    end else begin
                        state_q <= PPP_S_DONE;
                    end
                end
                PPP_S_READ: if (tmr_done) begin
                    state_q <= PPP_S_DONE;
                end
                PPP_S_DONE:  state_q <= PPP_S_IDLE;
                default:     state_q <= PPP_S_IDLE;
            endcase
        end
    end

    // ************************************************
    // response
    // ************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rsp_valid <= 1'b0;
            rsp_ok    <= 1'b0;
            rsp_blank <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_tries <= 4'h0;
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= (state_q == PPP_S_IDLE) && !(cmd_valid && addr_ok);
            rsp_valid <= 1'b0;
            if ((state_q == PPP_S_READ || state_q == PPP_S_VERI) && tmr_done) begin
                rsp_rdata <= din_s2_q;  // sample after access time
                rsp_blank <= (din_s2_q == ERASED_BYTE);
            end
            if (state_q == PPP_S_IDLE && cmd_valid && !addr_ok) begin
                rsp_valid <= 1'b1;
                rsp_ok    <= 1'b0;
                rsp_tries <= 4'h0;
            end else if (state_q == PPP_S_DONE) begin
                rsp_valid <= 1'b1;
                rsp_ok    <= (op_q == PPP_CMD_READ) || !mismatch_q;
                rsp_tries <= tries_q;
            end
        end
    end

    // ************************************************
    // pin drive
    // ************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dev_reset_n        <= 1'b1;
            vpp_on             <= 1'b0;
            vpp_write_sel      <= 1'b0;
            enable_strobe_n    <= 1'b1;
            read_strobe_n      <= 1'b1;
            program_strobe_n   <= 1'b1;
            prog_addr_bus      <= ADDR_FIRST;
            prog_data_bus_o    <= 8'h00;
            prog_data_bus_oe_n <= 1'b1;
        end else begin
            // device held in reset with supply up whenever a job runs
            dev_reset_n   <= (state_q == PPP_S_IDLE);
            vpp_on        <= (state_q != PPP_S_IDLE);
            vpp_write_sel <= (op_q != PPP_CMD_READ) && (state_q != PPP_S_IDLE)
                             && (state_q != PPP_S_DONE);
            prog_addr_bus <= cur_addr;
            prog_data_bus_o <= cur_byte;
            enable_strobe_n    <= 1'b1;
            read_strobe_n      <= 1'b1;
            program_strobe_n   <= 1'b1;   // idle high inhibits programming
            prog_data_bus_oe_n <= 1'b1;   // float before device may drive
            case (state_q)
                PPP_S_LATCH: begin
                    read_strobe_n      <= 1'b0;
                    prog_data_bus_oe_n <= 1'b0;
                end
                PPP_S_GAP, PPP_S_PULSE: begin
                    if (op_q == PPP_CMD_BYTE) begin
                        enable_strobe_n    <= 1'b0;
                        prog_data_bus_oe_n <= 1'b0;
                    end
                    program_strobe_n <= (state_q != PPP_S_PULSE);
                end
                PPP_S_VERI, PPP_S_READ: begin
                    enable_strobe_n <= 1'b0;
                    read_strobe_n   <= 1'b0;
                end
                default: ;  // standby keeps device bus floating
            endcase
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence s_pulse_start;
        $fell(program_strobe_n);
    endsequence

    property p_mode_entry;
        @(posedge clk) disable iff (!nrst)
        !read_strobe_n |-> (!dev_reset_n && vpp_on);
    endproperty
    a_mode_entry: assert property (p_mode_entry)
        else $error("strobe active outside programming mode");

    property p_pulse_strobes;
        @(posedge clk) disable iff (!nrst)
        !program_strobe_n |-> (read_strobe_n && vpp_write_sel);
    endproperty
    a_pulse_strobes: assert property (p_pulse_strobes)
        else $error("program pulse with read strobe low");

    property p_pulse_len;
        @(posedge clk) disable iff (!nrst)
        s_pulse_start |-> !program_strobe_n [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("program pulse too short");

    property p_no_contention;
        @(posedge clk) disable iff (!nrst)
        !read_strobe_n && !enable_strobe_n |-> prog_data_bus_oe_n;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives bus during device read");

    property p_byte_write;
        @(posedge clk) disable iff (!nrst)
        (!program_strobe_n && op_q == PPP_CMD_BYTE) |->
            (!enable_strobe_n && !prog_data_bus_oe_n);
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write without enable or data");

    property p_tries_cap;
        @(posedge clk) disable iff (!nrst)
        tries_q <= MAX_TRIES;
    endproperty
    a_tries_cap: assert property (p_tries_cap)
        else $error("more than ten write attempts");

    property p_addr_range;
        @(posedge clk) disable iff (!nrst)
        !program_strobe_n |-> prog_addr_bus <= ADDR_LAST;
    endproperty
    a_addr_range: assert property (p_addr_range)
        else $error("write outside program area");

    property p_latch_mode;
        @(posedge clk) disable iff (!nrst)
        (!read_strobe_n && enable_strobe_n) |->
            (program_strobe_n && !prog_data_bus_oe_n && vpp_write_sel);
    endproperty
    a_latch_mode: assert property (p_latch_mode)
        else $error("page latch strobes wrong");

endmodule // ppp_host

/* File: ppp_pkg.sv */
// package: constants and types for the prom programming port controller
package ppp_pkg;

    // ************************************************
    // bus widths
    // ************************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // ************************************************
    // address range and erased value
    // ************************************************
    localparam logic [16:0] ADDR_FIRST  = 17'h00000;
    localparam logic [16:0] ADDR_LAST   = 17'h0EFFF;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    // ************************************************
    // page and retry limits
    // ************************************************
    localparam int           PAGE_BYTES  = 4;
    localparam logic [3:0]   MAX_TRIES   = 4'hA;
    localparam logic [1:0]   PAGE_IDX_LAST = 2'h3;

    // ************************************************
    // timing at 40 MHz
    // ************************************************
    localparam int CLK_PERIOD_NS  = 25;
    localparam int PULSE_TIME_NS  = 100000;   // 0.1 ms program pulse
    localparam int PULSE_CYC      = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_TIME_NS  = 1000;     // setup/access margin
    localparam int SETUP_CYC      = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W        = 16;

    // ************************************************
    // commands
    // ************************************************
    typedef enum logic [1:0] {
        PPP_CMD_READ  = 2'h0,
        PPP_CMD_BYTE  = 2'h1,
        PPP_CMD_PAGE  = 2'h2
    } ppp_cmd_t;

    // ************************************************
    // sequencer states
    // ************************************************
    typedef enum logic [7:0] {
        PPP_S_IDLE  = 8'h01,
        PPP_S_LATCH = 8'h02,
        PPP_S_GAP   = 8'h04,
        PPP_S_PULSE = 8'h08,
        PPP_S_SETV  = 8'h10,
        PPP_S_VERI  = 8'h20,
        PPP_S_READ  = 8'h40,
        PPP_S_DONE  = 8'h80
    } ppp_state_t;

endpackage

/* File: ppp_timer.sv */
// file: down counter used to time strobes and setup gaps
`timescale 1ns/100ps
module ppp_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // status
    output logic              expired
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // load stays out of this term: the sequencer derives load from expired, so it would loop
    assign expired = (cnt_q == '0);
endmodule // ppp_timer

/* File: tb_top.sv */
// self-checking bench: controller against a device model and a reference memory
`timescale 1ns/100ps
module tb_top;
    import ppp_pkg::*;
    localparam int PC = 8;
    // pin register plus two sync flops: a sampling window below 3 cycles reads stale data
    localparam int SC = 4;
    logic        clk = 1'b0;
    logic        nrst;
    logic        cmd_valid;
    ppp_cmd_t    cmd_op;
    logic [16:0] cmd_addr;
    logic [31:0] cmd_wdata;
    logic        cmd_ready, rsp_valid, rsp_ok, rsp_blank;
    logic [7:0]  rsp_rdata, d_o, d_i;
    logic [3:0]  rsp_tries;
    logic        rst_n, wsel, v_on, ce_n, oe_n, pgm_n, d_oe_n;
    logic [16:0] a_bus;
    logic [7:0]  exp_mem [int];
    int          fails = 0;
    int          samples_checked = 0;
    int          seed = 32'haacb8ef8;
    int          a;

    ppp_host #(.PULSE_CYCLES(PC), .SETUP_CYCLES(SC)) uut (
        .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
        .rsp_blank(rsp_blank), .rsp_rdata(rsp_rdata), .rsp_tries(rsp_tries),
        .dev_reset_n(rst_n), .vpp_write_sel(wsel), .vpp_on(v_on), .enable_strobe_n(ce_n),
        .read_strobe_n(oe_n), .program_strobe_n(pgm_n), .prog_addr_bus(a_bus),
        .prog_data_bus_o(d_o), .prog_data_bus_oe_n(d_oe_n), .prog_data_bus_i(d_i));

    ppp_dev_model #(.MIN_PULSE_NS(PC * 25)) dev (
        .dev_reset_n(rst_n), .vpp_on(v_on), .vpp_write_sel(wsel), .enable_strobe_n(ce_n),
        .read_strobe_n(oe_n), .program_strobe_n(pgm_n), .prog_addr_bus(a_bus),
        .host_d(d_o), .host_oe_n(d_oe_n), .bus_d(d_i));

    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [7:0] ex(input int x);
        return exp_mem.exists(x) ? exp_mem[x] : 8'hFF;
    endfunction

    function automatic int ra();
        return int'($unsigned($random(seed)) % 32'hF000);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // called at a falling edge; the request is dropped at the next one
    task automatic send(input ppp_cmd_t op, input logic [16:0] ad, input logic [31:0] w);
        int n;
        n = 0;
        // one edge apart from the previous call, so cmd_valid is not set twice in one step
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cmd_op    = op;
        cmd_addr  = ad;
        cmd_wdata = w;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 6000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 6000) fails++;
    endtask

    task automatic rd(input int x);
        send(PPP_CMD_READ, 17'(x), 32'h0);
        check(rsp_ok, 1'b1);
        check(rsp_rdata, ex(x));
        check(rsp_blank, ex(x) == 8'hFF);
    endtask

    task automatic wr(input ppp_cmd_t op, input int x, input logic [31:0] w, input int f);
        int         n;
        logic [7:0] old;
        n   = (op == PPP_CMD_PAGE) ? 4 : 1;
        old = ex(x);
        dev.fail_left = f;
        send(op, 17'(x), w);
        check(rsp_ok, f < 10);
        check(rsp_tries, (f < 10) ? f + 1 : 10);
        if (n == 1) check(rsp_rdata, (f < 10) ? w[7:0] : old);
        for (int k = 0; k < n; k++) begin
            if (f < 10) exp_mem[x + k] = w[8*k +: 8];
            rd(x + k);
        end
        dev.fail_left = 0;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // the whole run needs well under a quarter of this
    initial begin
        #2000000;
        fails++;
        results();
    end

    initial begin
        nrst      = 1'b0;
        cmd_valid = 1'b0;
        cmd_op    = PPP_CMD_READ;
        cmd_addr  = '0;
        cmd_wdata = '0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        check(cmd_ready, 1'b1);
        check(rst_n, 1'b1);
        for (int i = 0; i < 4; i++) rd(ra());
        rd(0);
        rd(32'hEFFF);
        $display("test erased read done");
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 0 : (i == 1) ? 32'hEFFF : ra();
            wr(PPP_CMD_BYTE, a, $random(seed), 0);
        end
        $display("test byte write done");
        for (int j = 0; j < 4; j++) begin
            a = ra();
            wr(PPP_CMD_BYTE, a, {24'h0, ~ex(a)}, (j == 0) ? 1 : (j == 1) ? 3 : (j == 2) ? 9 : 12);
        end
        $display("test byte retry done");
        for (int j = 0; j < 4; j++) begin
            a = (j == 0) ? 0 : (j == 1) ? 32'hEFFC : (ra() & ~3);
            wr(PPP_CMD_PAGE, a, $random(seed), (j == 3) ? 2 : 0);
        end
        $display("test page write done");
        send(PPP_CMD_BYTE, 17'h0F000, 32'h12);
        check(rsp_ok, 1'b0);
        send(PPP_CMD_PAGE, 17'h1FFFC, 32'h12345678);
        check(rsp_ok, 1'b0);
        rd(32'hEFFF);
        check(dev.clash, 0);
        check(dev.bad_mode, 0);
        $display("test refused write done");
        results();
    end
endmodule // tb_top
